// ===== cssw_top.v
// Clock source select switch with AXI4-Lite register access
`include "cssw_consts.vh"

module cssw_top #(
  parameter ADDR_W = 4                        // Byte address width of the map
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              clock_input_pin,
  input  wire              rc_clock,
  input  wire              crystal_clock,
  input  wire              stop_mode,
  input  wire              system_osc_enable,
  output reg               clock_output_pin,
  output reg               clock_output_pin_oe_n,
  output reg               input_pin_clock_enable,
  output reg               crystal_amp_enable,
  output reg               internal_osc_clock,
  output reg               clock_x4,
  output reg               clock_x2
);

  // Switch sequencer states
  localparam ST_INT     = 3'h0;             // Running from internal oscillator
  localparam ST_COUNT   = 3'h1;             // Counting external rising edges
  localparam ST_ENGAGE  = 3'h2;             // Engaged flag set, internal still on
  localparam ST_EXT     = 3'h3;             // Running from external source
  localparam ST_RESTART = 3'h4;             // Internal restarted, external held

  // Software-visible state
  reg  [1:0]  source_select;                // Clock source option
  reg  [1:0]  internal_freq_select;         // Internal oscillator frequency
  reg  [1:0]  crystal_range_select;         // Crystal amplifier range
  reg         external_clock_request;       // Request to engage external clock
  reg         external_clock_engaged;       // External clock drives the system
  reg  [7:0]  trim_setting;                 // Signed trim of internal period
  reg         pin_clock_out_enable;         // Route x4 to output pin
  reg         run_in_stop;                  // Keep oscillator alive in stop
  // Sequencer and oscillator state
  reg  [2:0]  state;                        // Switch sequencer state
  reg  [1:0]  edge_count;                   // External rising edges seen
  reg         ext_prev;                     // Previous external source level
  reg         internal_run;                 // Internal oscillator running
  reg  [15:0] phase;                        // Internal oscillator accumulator
  // Bus holding registers
  reg              aw_held;                 // Write address captured
  reg              w_held;                  // Write data captured
  reg [ADDR_W-1:0] aw_addr;                 // Captured write address
  reg [7:0]        w_byte;                  // Captured low data byte
  reg              w_lane0;                 // Low byte lane strobe
  // Combinational helpers
  reg  [15:0] base_inc;                     // Nominal increment for frequency
  reg  [15:0] phase_inc;                    // Trimmed increment
  reg         ext_src;                      // Level of selected external source
  reg  [31:0] rd_word;                      // Read mux result
  reg         rd_hit;                       // Read address mapped
  wire [8:0]  trim_step;                    // One trim step, about 0.2 percent
  wire [16:0] trim_prod;                    // Signed trim times step
  wire        osc_allowed;                  // Power gate for all oscillators
  wire        src_rise;                     // Rising edge on external source
  wire        wr_go;                        // Both write halves present
  wire        next_clock_x4;                // Level x4 takes at the next edge

  // Wait mode has no input here: nothing in the block reacts to it
  // Stop mode halts sources unless the system enable or override keeps them
  assign osc_allowed = ~stop_mode | system_osc_enable | run_in_stop;
  assign src_rise = ext_src & ~ext_prev;
  assign wr_go    = aw_held & w_held & ~s_axi_bvalid;

  // Nominal increment; reserved code falls back to the default rate
  always @* begin
    case (internal_freq_select)
      `CSSW_FREQ_4M0: base_inc = `CSSW_INC_4M0;
      `CSSW_FREQ_8M0: base_inc = `CSSW_INC_8M0;
      default:        base_inc = `CSSW_INC_12M8;
    endcase
  end

  // Trim scales the increment: positive trim slows the oscillator
  assign trim_step = base_inc[15:7];
  assign trim_prod = $signed({{9{trim_setting[7]}}, trim_setting}) * $signed({8'h00, trim_step[8:2]});
  always @* begin
    phase_inc = base_inc - trim_prod[15:0];
  end

  // Pick the external source by option code
  always @* begin
    case (source_select)
      `CSSW_SRC_EXT: ext_src = clock_input_pin;
      `CSSW_SRC_RC:  ext_src = rc_clock;
      `CSSW_SRC_XTAL: ext_src = crystal_clock;
      default:       ext_src = 1'b0;
    endcase
  end

  // Internal oscillator model, a phase accumulator on aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase              <= 16'h0000;
      internal_osc_clock <= 1'b0;
    end else if (internal_run & osc_allowed) begin
      phase              <= phase + phase_inc;
      internal_osc_clock <= phase[15];
    end else begin
      // Stopped: hold low so restart begins cleanly
      phase              <= 16'h0000;
      internal_osc_clock <= 1'b0;
    end
  end

  // Switch sequencer between internal and external clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      state                  <= ST_INT;
      edge_count             <= 2'h0;
      ext_prev               <= 1'b0;
      internal_run           <= 1'b1;
      external_clock_engaged <= 1'b0;
    end else begin
      ext_prev <= ext_src;
      case (state)
        ST_INT: begin
          edge_count <= 2'h0;
          // Request only counts once an external option is chosen
          if (external_clock_request && source_select != `CSSW_SRC_INT) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (!external_clock_request) begin
            // Request withdrawn before the switch
            state <= ST_INT;
          end else if (src_rise) begin
            edge_count <= edge_count + 2'h1;
            if (edge_count + 2'h1 == `CSSW_EDGES_NEEDED) begin
              state                  <= ST_ENGAGE;
              external_clock_engaged <= 1'b1;
            end
          end
        end
        ST_ENGAGE: begin
          // Internal stops only after the flag is visible
          internal_run <= 1'b0;
          state        <= ST_EXT;
        end
        ST_EXT: begin
          if (!external_clock_request && source_select == `CSSW_SRC_INT) begin
            internal_run <= 1'b1;
            state        <= ST_RESTART;
          end
        end
        ST_RESTART: begin
          // Drop the flag once the internal source runs again
          external_clock_engaged <= 1'b0;
          state                  <= ST_INT;
        end
        default: begin
          state <= ST_INT;
        end
      endcase
    end
  end

  // Level for x4: low when stopped or during the engage cycle, external once engaged, else internal
  assign next_clock_x4 = ~osc_allowed ? 1'b0 :
                         external_clock_engaged ? (state != ST_ENGAGE) & ext_src : internal_osc_clock;

  // Clock register and divider; x2 toggles only where x4 itself rises, so the pair never drifts apart
  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_x4 <= 1'b0;
      clock_x2 <= 1'b0;
    end else begin
      clock_x4 <= next_clock_x4;
      if (~clock_x4 & next_clock_x4) begin
        clock_x2 <= ~clock_x2;
      end
    end
  end

  // Pin enables and output pin drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      input_pin_clock_enable <= 1'b0;
      crystal_amp_enable     <= 1'b0;
      clock_output_pin       <= 1'b0;
      clock_output_pin_oe_n  <= 1'b1;
    end else begin
      input_pin_clock_enable <= (source_select != `CSSW_SRC_INT) & osc_allowed;
      crystal_amp_enable     <= (source_select == `CSSW_SRC_XTAL) & osc_allowed;
      case (source_select)
        `CSSW_SRC_XTAL: begin
          // Amplifier output, the enable bit is ignored here
          clock_output_pin      <= ~clock_input_pin;
          clock_output_pin_oe_n <= ~osc_allowed;
        end
        `CSSW_SRC_EXT: begin
          // Pin left to general-purpose use
          clock_output_pin      <= 1'b0;
          clock_output_pin_oe_n <= 1'b1;
        end
        default: begin
          clock_output_pin      <= pin_clock_out_enable & clock_x4;
          clock_output_pin_oe_n <= ~pin_clock_out_enable;
        end
      endcase
    end
  end

  // Write channel capture and register update
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready          <= 1'b0;
      s_axi_wready           <= 1'b0;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= `CSSW_RESP_OKAY;
      aw_held                <= 1'b0;
      w_held                 <= 1'b0;
      aw_addr                <= {ADDR_W{1'b0}};
      w_byte                 <= 8'h00;
      w_lane0                <= 1'b0;
      source_select          <= `CSSW_SRC_INT;
      internal_freq_select   <= `CSSW_RST_FREQ;
      crystal_range_select   <= 2'h0;
      external_clock_request <= 1'b0;
      trim_setting           <= `CSSW_RST_TRIM;
      pin_clock_out_enable   <= 1'b0;
      run_in_stop            <= 1'b0;
    end else begin
      // Ready pulses for one cycle per captured half
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CSSW_RESP_OKAY;
        case (aw_addr)
          `CSSW_OFF_CTRL: begin
            if (w_lane0) begin
              source_select          <= w_byte[`CSSW_SRC_LSB +: 2];
              internal_freq_select   <= w_byte[`CSSW_FREQ_LSB +: 2];
              crystal_range_select   <= w_byte[`CSSW_RANGE_LSB +: 2];
              external_clock_request <= w_byte[`CSSW_REQ_BIT];
            end
          end
          `CSSW_OFF_TRIM: begin
            if (w_lane0) begin
              trim_setting <= w_byte;
            end
          end
          `CSSW_OFF_CFG: begin
            if (w_lane0) begin
              pin_clock_out_enable <= w_byte[`CSSW_PINOUT_BIT];
              run_in_stop          <= w_byte[`CSSW_RUNSTOP_BIT];
            end
          end
          default: begin
            s_axi_bresp <= `CSSW_RESP_SLVERR;
          end
        endcase
      end
      // External clock mode keeps the pin output enable cleared
      if (source_select == `CSSW_SRC_EXT) begin
        pin_clock_out_enable <= 1'b0;
      end
    end
  end

  // Read mux over the map
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `CSSW_OFF_CTRL: begin
        rd_word[`CSSW_SRC_LSB +: 2]   = source_select;
        rd_word[`CSSW_FREQ_LSB +: 2]  = internal_freq_select;
        rd_word[`CSSW_RANGE_LSB +: 2] = crystal_range_select;
        rd_word[`CSSW_REQ_BIT]        = external_clock_request;
        rd_word[`CSSW_ENG_BIT]        = external_clock_engaged;
      end
      `CSSW_OFF_TRIM: begin
        rd_word[7:0] = trim_setting;
      end
      `CSSW_OFF_CFG: begin
        rd_word[`CSSW_PINOUT_BIT]  = pin_clock_out_enable;
        rd_word[`CSSW_RUNSTOP_BIT] = run_in_stop;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: accept, then answer on the next edge; no interrupt output exists
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CSSW_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `CSSW_RESP_OKAY : `CSSW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cssw_top

// ===== cssw_consts.vh
// Constants for the clock source select switch: offsets, fields, resets, timing
`ifndef CSSW_CONSTS_VH
`define CSSW_CONSTS_VH

// Register byte offsets
`define CSSW_OFF_CTRL        4'h0
`define CSSW_OFF_TRIM        4'h4
`define CSSW_OFF_CFG         4'h8

// Control/status register fields
`define CSSW_SRC_LSB         0
`define CSSW_FREQ_LSB        2
`define CSSW_RANGE_LSB       4
`define CSSW_REQ_BIT         6
`define CSSW_ENG_BIT         7

// Configuration register fields
`define CSSW_PINOUT_BIT      0
`define CSSW_RUNSTOP_BIT     1

// Source select encodings
`define CSSW_SRC_INT         2'h0
`define CSSW_SRC_EXT         2'h1
`define CSSW_SRC_RC          2'h2
`define CSSW_SRC_XTAL        2'h3

// Internal frequency encodings
`define CSSW_FREQ_4M0        2'h0
`define CSSW_FREQ_8M0        2'h1
`define CSSW_FREQ_12M8       2'h2

// Reset values
`define CSSW_RST_FREQ        2'h2
`define CSSW_RST_TRIM        8'h00

// Phase increments for a 16-bit accumulator at 40 MHz (f * 65536 / 40 MHz)
`define CSSW_INC_12M8        16'h51EC
`define CSSW_INC_8M0         16'h3333
`define CSSW_INC_4M0         16'h199A

// Source edges to see before switching over
`define CSSW_EDGES_NEEDED    2'h2

// Bus responses
`define CSSW_RESP_OKAY       2'h0
`define CSSW_RESP_SLVERR     2'h2

`endif

// ===== cssw_top_monitor.sv
// Checker for bus handshakes and clock outputs of the source switch
module cssw_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_x4,
  input wire logic clock_x2,
  input wire logic clock_output_pin_oe_n,
  input wire logic crystal_amp_enable,
  input wire logic input_pin_clock_enable
);
  // One clock domain, so one default for all checks
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both write halves taken on the same edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  aw_ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready stood for two cycles");
  write_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late or missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  read_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not offered after address");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped before rready");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read taken while data pending");
  x2_follow_a: assert property ($rose(clock_x4) |-> ##[0:1] $changed(clock_x2))
    else $error("x2 did not toggle on x4 rise");
  x2_only_a: assert property ($changed(clock_x2) |-> clock_x4 || $past(clock_x4))
    else $error("x2 toggled without x4 rise");
  xtal_drive_a: assert property (crystal_amp_enable && $past(crystal_amp_enable) |-> !clock_output_pin_oe_n)
    else $error("output pin not driven in crystal mode");
  xtal_input_a: assert property (crystal_amp_enable |-> input_pin_clock_enable)
    else $error("crystal amp on without input pin clock");
endmodule // cssw_top_monitor

// ===== cssw_ext_source.sv
// Far-side model: external clock driver, RC network and crystal
module cssw_ext_source #(
  parameter int EXT_HALF  = 5,  // Driver half period, aclk cycles
  parameter int RC_HALF   = 4,  // RC half period
  parameter int XTAL_HALF = 8   // Crystal half period
) (
  input  wire logic aclk,
  input  wire logic pin_enable,
  input  wire logic amp_enable,
  output wire logic clock_input_pin,
  output logic      rc_clock = 1'b0,
  output logic      crystal_clock = 1'b0
);
  logic ext_drv = 1'b0;  // External driver level
  int   n_ext = 0;       // Half-period counters
  int   n_rc = 0;
  int   n_x = 0;
  // Crystal node appears on the input pin while the amplifier runs
  assign clock_input_pin = amp_enable ? crystal_clock : ext_drv;
  // Sources oscillate only once enabled, held low otherwise; slow enough to be sampled on aclk
  always @(posedge aclk) begin
    n_ext <= (pin_enable && n_ext < EXT_HALF - 1) ? n_ext + 1 : 0;
    n_rc <= (pin_enable && n_rc < RC_HALF - 1) ? n_rc + 1 : 0;
    n_x <= (amp_enable && n_x < XTAL_HALF - 1) ? n_x + 1 : 0;
    ext_drv <= pin_enable && (n_ext == EXT_HALF - 1 ? !ext_drv : ext_drv);
    rc_clock <= pin_enable && (n_rc == RC_HALF - 1 ? !rc_clock : rc_clock);
    crystal_clock <= amp_enable && (n_x == XTAL_HALF - 1 ? !crystal_clock : crystal_clock);
  end
endmodule // cssw_ext_source

// ===== cssw_top_tb.sv
// Self-checking bench for the clock source select switch
`include "cssw_consts.vh"
module cssw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        stop_mode = 1'b0, system_osc_enable = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         clock_input_pin, rc_clock, crystal_clock, clock_output_pin, clock_output_pin_oe_n;
  wire         input_pin_clock_enable, crystal_amp_enable, clock_x4, clock_x2, internal_osc_clock;
  int          errors = 0, n_tests = 0;
  int          r4, r2, rp, ri, hi, lo;
  logic [31:0] d;
  // Expected rises per 1000 cycles, per frequency code and per source
  int          fexp[4] = '{100, 200, 320, 320};
  int          sexp[4] = '{320, 100, 125, 62};
  logic [31:0] cfg_rd[4] = '{32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] oe_exp[4] = '{32'h0, 32'h1, 32'h0, 32'h0};
  localparam logic [31:0] CTRL_RST = 32'(`CSSW_RST_FREQ) << `CSSW_FREQ_LSB;

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  cssw_top u_cssw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .clock_input_pin, .rc_clock, .crystal_clock, .stop_mode, .system_osc_enable,
    .clock_output_pin, .clock_output_pin_oe_n, .input_pin_clock_enable, .crystal_amp_enable,
    .internal_osc_clock, .clock_x4, .clock_x2);

  cssw_ext_source u_cssw_ext_source (.aclk, .pin_enable(input_pin_clock_enable),
    .amp_enable(crystal_amp_enable), .clock_input_pin, .rc_clock, .crystal_clock);

  // Verdict and end of run
  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compare, exact when tol is zero, else within tol
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    n_tests++;
    if (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp)) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, held until each is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; !done; k++) begin
      @(posedge aclk);
      if (k == 60) begin errors++; close_out(); end
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        done = 1;
        chk(s_axi_bresp, er, 0);
      end
    end
  endtask

  // Bus read: data and response taken on the edge rvalid is seen
  task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] q);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; !done; k++) begin
      @(posedge aclk);
      if (k == 60) begin errors++; close_out(); end
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        q = s_axi_rdata;
        done = 1;
        chk(s_axi_rresp, er, 0);
      end
    end
  endtask

  // Rising edges of x4, x2 and the output pin over 1000 cycles
  task automatic cnt();
    logic p4, p2, pp, pi;
    r4 = 0; r2 = 0; rp = 0; ri = 0;
    p4 = clock_x4; p2 = clock_x2; pp = clock_output_pin; pi = internal_osc_clock;
    repeat (1000) begin
      @(posedge aclk);
      r4 += (clock_x4 === 1'b1 && p4 === 1'b0);
      r2 += (clock_x2 === 1'b1 && p2 === 1'b0);
      rp += (clock_output_pin === 1'b1 && pp === 1'b0);
      ri += (internal_osc_clock === 1'b1 && pi === 1'b0);
      p4 = clock_x4; p2 = clock_x2; pp = clock_output_pin; pi = internal_osc_clock;
    end
  endtask

  // Poll engaged status, bounded
  task automatic wait_eng(input logic want);
    logic [31:0] q;
    for (int k = 0; k < 40; k++) begin
      rd(`CSSW_OFF_CTRL, `CSSW_RESP_OKAY, q);
      if (q[`CSSW_ENG_BIT] === want) return;
    end
    errors++;
    close_out();
  endtask

  initial begin
    // Reset held six cycles
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CSSW_OFF_CTRL, `CSSW_RESP_OKAY, d); chk(d, CTRL_RST, 0);
    rd(`CSSW_OFF_TRIM, `CSSW_RESP_OKAY, d); chk(d, 32'h0, 0);
    rd(`CSSW_OFF_CFG, `CSSW_RESP_OKAY, d); chk(d, 32'h0, 0);
    // Unmapped place refused
    rd(4'hC, `CSSW_RESP_SLVERR, d); chk(d, 32'h0, 0);
    wr(4'hC, 32'hFF, `CSSW_RESP_SLVERR);
    // Each internal frequency code, the reserved one runs at the default rate
    for (int f = 0; f < 4; f++) begin
      wr(`CSSW_OFF_CTRL, 32'(f) << `CSSW_FREQ_LSB, `CSSW_RESP_OKAY);
      cnt(); chk(r4, fexp[f], 2);
      chk(ri, fexp[f], 2);
      chk(r2, fexp[f] / 2, 2);
    end
    // Trim extremes: software loads the value itself
    wr(`CSSW_OFF_TRIM, 32'h7F, `CSSW_RESP_OKAY);
    rd(`CSSW_OFF_TRIM, `CSSW_RESP_OKAY, d); chk(d, 32'h7F, 0);
    cnt(); hi = r4;
    wr(`CSSW_OFF_TRIM, 32'h80, `CSSW_RESP_OKAY);
    rd(`CSSW_OFF_TRIM, `CSSW_RESP_OKAY, d); chk(d, 32'h80, 0);
    cnt(); lo = r4;
    wr(`CSSW_OFF_TRIM, 32'h0, `CSSW_RESP_OKAY);
    cnt(); chk(32'(hi < r4 - 20 && lo > r4 + 20), 32'h1, 0);
    // Internal clock out on the pin
    wr(`CSSW_OFF_CFG, 32'h1, `CSSW_RESP_OKAY);
    cnt(); chk(rp, 320, 2);
    chk(clock_output_pin_oe_n, 32'h0, 0);
    wr(`CSSW_OFF_CFG, 32'h0, `CSSW_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(clock_output_pin_oe_n, 32'h1, 0);
    // Stop mode with and without overrides
    stop_mode <= 1'b1;
    system_osc_enable <= 1'b0;
    // One edge for the stop to take hold, else a rise launched just before it is counted
    @(posedge aclk);
    cnt(); chk(r4, 0, 0);
    wr(`CSSW_OFF_CFG, 32'h2, `CSSW_RESP_OKAY);
    cnt(); chk(r4, 320, 2);
    wr(`CSSW_OFF_CFG, 32'h0, `CSSW_RESP_OKAY);
    system_osc_enable <= 1'b1;
    cnt(); chk(r4, 320, 2);
    stop_mode <= 1'b0;
    // External clock, RC, crystal: switch over, and back for all but the crystal
    for (int s = 1; s < 4; s++) begin
      wr(`CSSW_OFF_CTRL, CTRL_RST | 32'(s), `CSSW_RESP_OKAY);
      // Crystal settles for 4096 of its own periods, 16 cycles each; other sources need less
      repeat (s == 3 ? 65536 : 200) @(posedge aclk);
      wr(`CSSW_OFF_CTRL, CTRL_RST | 32'h40 | 32'(s), `CSSW_RESP_OKAY);
      wait_eng(1'b1);
      wr(`CSSW_OFF_CFG, 32'h1, `CSSW_RESP_OKAY);
      rd(`CSSW_OFF_CFG, `CSSW_RESP_OKAY, d); chk(d, cfg_rd[s], 0);
      cnt(); chk(r4, sexp[s], 2);
      chk(ri, 0, 0);
      chk(clock_output_pin_oe_n, oe_exp[s], 0);
      if (s > 1) chk(rp, sexp[s], 2);
      if (s < 3) begin
        wr(`CSSW_OFF_CTRL, CTRL_RST, `CSSW_RESP_OKAY);
        wait_eng(1'b0);
        cnt(); chk(r4, 320, 2);
        chk(ri, 320, 2);
      end
    end
    // Reset while engaged on the crystal
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CSSW_OFF_CTRL, `CSSW_RESP_OKAY, d); chk(d, CTRL_RST, 0);
    cnt(); chk(r4, 320, 2);
    close_out();
  end
endmodule // cssw_top_tb

bind cssw_top cssw_top_monitor u_cssw_top_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .clock_x4, .clock_x2, .clock_output_pin_oe_n, .crystal_amp_enable, .input_pin_clock_enable);
